// >>> include/icc_pkg.sv
// Purpose: Shared constants for the input check and channel configuration block
// Assumes: 16-bit register words, register index as printed
// Notes:   Reserved bits are masked on write so that they read as zero
package icc_pkg;

   localparam int          REG_W          = 16;
   localparam int          ADDR_W         = 7;
   localparam int          DATA_W         = 16;

   // Register index
   localparam logic [6:0]  CFG_ADDR       = 7'h01;

   // Field positions
   localparam int          BIT_IOTEST     = 15;
   localparam int          BIT_AUTOCLR    = 12;
   localparam int          BIT_ODD        = 11;
   localparam int          BIT_WORD_PAR   = 10;
   localparam int          BIT_FRAME_PAR  = 9;
   localparam int          BIT_QUAD       = 8;
   localparam int          BIT_INV_A      = 7;

   // Reset value and writable-bit mask (bits 14 and 13 reserved)
   localparam logic [15:0] CFG_RESET      = 16'h050e;
   localparam logic [15:0] CFG_WMASK      = 16'h9fff;

   // Dual mode code in bits 13:12 of the sixteenth config register
   localparam logic [1:0]  DUAL_CODE      = 2'h3;
   localparam logic [3:0]  CH_ALL         = 4'hf;
   localparam logic [3:0]  CH_BC          = 4'h6;

   // Good samples in a row before alarms clear themselves
   localparam int          GOOD_RUN       = 64;

   typedef enum logic [1:0] {
      ICC_NORMAL,
      ICC_IOTEST
   } icc_mode_t;

endpackage : icc_pkg

// >>> hdl/icc_parity_check.sv
// Purpose: Parity check of one input word against one parity source bit
// Assumes: Inputs synchronous to i_clk
// Notes:   Error is registered, one cycle after the sample
`timescale 1ns/1ps
module icc_parity_check #(
   parameter int DATA_W = 16
) (
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   // Sample
   input  wire logic              i_valid,
   input  wire logic              i_enable,
   input  wire logic              i_odd,
   input  wire logic [DATA_W-1:0] i_data,
   input  wire logic              i_parity_bit,
   // Result
   output logic                   o_error
);

   if (DATA_W < 1) begin : g_bad_width
      $error("icc_parity_check: DATA_W must be at least 1");
   end

   logic ones_odd;

   // Total of ones over data and parity bit is even for even sense, odd for odd sense
   assign ones_odd = (^i_data) ^ i_parity_bit;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_error <= 1'b0;
      end else begin
         o_error <= i_valid && i_enable && (ones_odd != i_odd);
      end
   end

endmodule : icc_parity_check

// >>> hdl/icc_input_check.sv
// Purpose: Input check and channel configuration register with its checkers
// Assumes: Serial interface decoded into a word-wide register strobe port
// Notes:   Only bits 15..7 steer logic here; bits 6..0 are stored and passed on
`timescale 1ns/1ps
module icc_input_check
   import icc_pkg::*;
#(
   parameter int DATA_W   = icc_pkg::DATA_W,
   parameter int GOOD_CNT = icc_pkg::GOOD_RUN
) (
   // Clock and reset
   input  wire logic                      i_clk,
   input  wire logic                      i_rst_n,
   // Register port from the serial interface
   input  wire logic [icc_pkg::ADDR_W-1:0] i_reg_addr,
   input  wire logic                      i_reg_wr,
   input  wire logic                      i_reg_rd,
   input  wire logic [icc_pkg::REG_W-1:0] i_reg_wdata,
   output logic      [icc_pkg::REG_W-1:0] o_reg_rdata,
   output logic                           o_reg_rvalid,
   // Input data bus
   input  wire logic                      i_data_valid,
   input  wire logic [DATA_W-1:0]         i_data,
   input  wire logic                      i_differential_parity_input,
   input  wire logic                      i_frame,
   input  wire logic [DATA_W-1:0]         i_pattern_word,
   // Other controls
   input  wire logic                      i_txenable,
   input  wire logic                      i_sif_txenable,
   input  wire logic [1:0]                i_sixteenth_config_register,
   input  wire logic                      i_alarm_clear,
   // Data path
   output logic                           o_data_valid,
   output logic      [DATA_W-1:0]         o_channel_a_data,
   output logic      [3:0]                o_channel_active,
   output logic                           o_analog_enable,
   // Status
   output logic                           o_alarm_pattern,
   output logic                           o_alarm_parity,
   output logic                           o_iotest_active,
   output logic      [6:0]                o_low_config
);

   import icc_pkg::*;

   if (DATA_W < 1) begin : g_bad_width
      $error("icc_input_check: DATA_W must be at least 1");
   end
   // Run counter is eight bits wide, so the run length must fit in it
   if (GOOD_CNT < 2 || GOOD_CNT > 255) begin : g_bad_run
      $error("icc_input_check: GOOD_CNT out of 2..255");
   end

   logic [REG_W-1:0] cfg_q;
   icc_mode_t        mode_q;
   logic [7:0]       good_cnt_q;
   logic [1:0]       par_err;
   logic             pat_err_q;
   logic             any_err;
   logic             run_done;
   logic             clear_evt;

   function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
      addr_hit = (a == CFG_ADDR);
   endfunction : addr_hit

   // Configuration register
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cfg_q <= CFG_RESET;
      end else if (i_reg_wr && addr_hit(i_reg_addr)) begin
         cfg_q <= i_reg_wdata & CFG_WMASK;
      end
   end

   // Read port answers one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_reg_rdata  <= '0;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg_rd;
         o_reg_rdata  <= (i_reg_rd && addr_hit(i_reg_addr)) ? cfg_q : '0;
      end
   end

   // Mode follows the pattern-test bit
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         mode_q <= ICC_NORMAL;
      end else begin
         mode_q <= cfg_q[BIT_IOTEST] ? ICC_IOTEST : ICC_NORMAL;
      end
   end

   // Word parity uses the dedicated input, frame parity the frame line
   logic [1:0] par_en;
   logic [1:0] par_bit;
   assign par_en  = {cfg_q[BIT_FRAME_PAR], cfg_q[BIT_WORD_PAR]};
   assign par_bit = {i_frame, i_differential_parity_input};

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_par
         icc_parity_check #(
            .DATA_W       (DATA_W)
         ) u_par (
            .i_clk        (i_clk),
            .i_rst_n      (i_rst_n),
            .i_valid      (i_data_valid),
            .i_enable     (par_en[g]),
            .i_odd        (cfg_q[BIT_ODD]),
            .i_data       (i_data),
            .i_parity_bit (par_bit[g]),
            .o_error      (par_err[g])
         );
      end
   endgenerate

   // Pattern checker compares each sample with the expected word in test mode
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         pat_err_q <= 1'b0;
      end else begin
         pat_err_q <= i_data_valid && (mode_q == ICC_IOTEST)
                      && (i_data != i_pattern_word);
      end
   end

   // A checked sample is any valid sample of the previous cycle, whether or not a checker is enabled
   logic checked_q;
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         checked_q <= 1'b0;
      end else begin
         checked_q <= i_data_valid;
      end
   end

   assign any_err = pat_err_q || (|par_err);

   // Run of good samples; a bad one restarts it
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         good_cnt_q <= '0;
      end else if (!cfg_q[BIT_AUTOCLR] || any_err) begin
         good_cnt_q <= '0;
      end else if (checked_q) begin
         if (run_done) begin
            good_cnt_q <= 8'h01;
         end else begin
            good_cnt_q <= good_cnt_q + 8'h01;
         end
      end
   end

   assign run_done  = (good_cnt_q == 8'(GOOD_CNT));
   // Clear from a register write or after the good run; a new error wins
   assign clear_evt = i_alarm_clear || (cfg_q[BIT_AUTOCLR] && run_done);

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_alarm_pattern <= 1'b0;
      end else if (pat_err_q) begin
         o_alarm_pattern <= 1'b1;
      end else if (clear_evt) begin
         o_alarm_pattern <= 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_alarm_parity <= 1'b0;
      end else if (|par_err) begin
         o_alarm_parity <= 1'b1;
      end else if (clear_evt) begin
         o_alarm_parity <= 1'b0;
      end
   end

   // Normal data path is stopped while the pattern test runs
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_data_valid     <= 1'b0;
         o_channel_a_data <= '0;
      end else begin
         o_data_valid <= i_data_valid && (mode_q == ICC_NORMAL);
         if (i_data_valid && (mode_q == ICC_NORMAL)) begin
            o_channel_a_data <= cfg_q[BIT_INV_A] ? ~i_data : i_data;
         end
      end
   end

   // Channel arrangement; quad cleared without the dual code keeps all four
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_channel_active <= CH_ALL;
      end else if (cfg_q[BIT_QUAD]) begin
         o_channel_active <= CH_ALL;
      end else if (i_sixteenth_config_register == DUAL_CODE) begin
         o_channel_active <= CH_BC;
      end else begin
         o_channel_active <= CH_ALL;
      end
   end

   // Pattern test overrides both transmit enables
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_analog_enable <= 1'b0;
      end else begin
         o_analog_enable <= i_txenable && i_sif_txenable
                            && !cfg_q[BIT_IOTEST];
      end
   end

   assign o_iotest_active = (mode_q == ICC_IOTEST);
   assign o_low_config    = cfg_q[6:0];

endmodule : icc_input_check

// >>> testbench/icc_input_check_props.sv
// Purpose: Port assertions for the input check block
// Assumes: Alarms rise two cycles after the sample that caused them
// Notes:   Sees only the top module ports
`timescale 1ns/1ps
module icc_input_check_props (
   input wire logic        i_clk,
   input wire logic        i_rst_n,
   input wire logic        i_reg_rd,
   input wire logic        i_data_valid,
   input wire logic        i_alarm_clear,
   input wire logic [1:0]  i_sixteenth_config_register,
   input wire logic [15:0] o_reg_rdata,
   input wire logic        o_reg_rvalid,
   input wire logic        o_data_valid,
   input wire logic [3:0]  o_channel_active,
   input wire logic        o_analog_enable,
   input wire logic        o_alarm_pattern,
   input wire logic        o_alarm_parity,
   input wire logic        o_iotest_active,
   input wire logic [6:0]  o_low_config
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   property p_rst;
      $rose(i_rst_n) |-> o_low_config == 7'h0e && o_channel_active == 4'hf;
   endproperty
   property p_rd;
      i_reg_rd |=> o_reg_rvalid;
   endproperty
   property p_rsvd;
      o_reg_rvalid |-> o_reg_rdata[14:13] == 2'h0;
   endproperty
   property p_off;
      o_iotest_active |-> !o_analog_enable;
   endproperty
   property p_nodata;
      o_iotest_active && $past(o_iotest_active) |-> !o_data_valid;
   endproperty
   property p_par;
      $rose(o_alarm_parity) |-> $past(i_data_valid, 2);
   endproperty
   property p_pat;
      $rose(o_alarm_pattern) |-> $past(i_data_valid, 2);
   endproperty
   property p_auto;
      $fell(o_alarm_parity) && $past(i_rst_n) && !$past(i_alarm_clear) |-> $past(i_data_valid, 3);
   endproperty
   property p_quad;
      $past(i_sixteenth_config_register) != 2'h3 |-> o_channel_active == 4'hf;
   endproperty
   property p_dual;
      o_channel_active != 4'hf |-> o_channel_active == 4'h6;
   endproperty
   a_rst: assert property (p_rst) else $error("reset values wrong");
   a_rd: assert property (p_rd) else $error("read gave no answer");
   a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
   a_off: assert property (p_off) else $error("outputs on in test");
   a_nodata: assert property (p_nodata) else $error("data out in test");
   a_par: assert property (p_par) else $error("parity alarm uncaused");
   a_pat: assert property (p_pat) else $error("pattern alarm uncaused");
   a_auto: assert property (p_auto) else $error("alarm cleared uncaused");
   a_quad: assert property (p_quad) else $error("channels not all on");
   a_dual: assert property (p_dual) else $error("bad channel set");
   c_par: cover property ($rose(o_alarm_parity));
   c_test: cover property (o_iotest_active);
   c_dual: cover property (o_channel_active == 4'h6);
endmodule : icc_input_check_props
bind icc_input_check icc_input_check_props u_props (.*);

// >>> testbench/icc_src_model.sv
// Purpose: Data source model for the input bus
// Assumes: Requests change just after the rising edge
// Notes:   Idle bus inverts its data each cycle, so stale values match again on every second idle cycle
`timescale 1ns/1ps
module icc_src_model (
   input  wire logic        i_clk,
   input  wire logic        i_go,
   input  wire logic        i_odd,
   input  wire logic        i_bad,
   input  wire logic [15:0] i_word,
   output logic             o_valid,
   output logic [15:0]      o_data,
   output logic             o_parity
);
   always_ff @(posedge i_clk) begin
      o_valid  <= i_go;
      o_data   <= i_go ? i_word : ~o_data;
      o_parity <= i_go ? (^i_word ^ i_odd ^ i_bad) : ~o_parity;
   end
endmodule : icc_src_model

// >>> testbench/input_check_channel_config_tb.sv
// Purpose: Self-checking bench for the input check block
// Assumes: GOOD_CNT shortened to 4 so auto-clear runs fast
// Notes:   Source model adds one cycle before the bus
`timescale 1ns/1ps
module input_check_channel_config_tb;
   import icc_pkg::*;
   logic        i_clk = 0, i_rst_n = 0, wr = 0, rd = 0, go = 0, odd = 0, bad = 0;
   logic        tx = 1, sif = 1, aclr = 0, wflip = 0, dv, aen, apat, apar, iot, rv, sv, sp;
   logic [1:0]  code = 0;
   logic [3:0]  act;
   logic [6:0]  addr = 0, low;
   logic [15:0] wd = 0, word = 0, pat = 0, rdat, cha, sd, r;
   int          failures = 0, n_checks = 0;
   always #50 i_clk = ~i_clk;
   icc_src_model src (.i_clk, .i_go(go), .i_odd(odd), .i_bad(bad), .i_word(word),
      .o_valid(sv), .o_data(sd), .o_parity(sp));
   icc_input_check #(.GOOD_CNT(4)) dut (.i_clk, .i_rst_n, .i_reg_addr(addr),
      .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wd), .o_reg_rdata(rdat),
      .o_reg_rvalid(rv), .i_data_valid(sv), .i_data(sd),
      .i_differential_parity_input(sp ^ wflip),
      .i_frame(sp ^ !wflip), .i_pattern_word(pat), .i_txenable(tx), .i_sif_txenable(sif),
      .i_sixteenth_config_register(code), .i_alarm_clear(aclr), .o_data_valid(dv),
      .o_channel_a_data(cha), .o_channel_active(act), .o_analog_enable(aen),
      .o_alarm_pattern(apat), .o_alarm_parity(apar), .o_iotest_active(iot),
      .o_low_config(low));
   task automatic chk(string n, logic [15:0] s, logic [15:0] e);
      n_checks++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic cyc(int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : cyc
   task automatic wreg(logic [6:0] a, logic [15:0] d);
      @(posedge i_clk);
      addr <= a;
      wd <= d;
      wr <= 1;
      @(posedge i_clk);
      wr <= 0;
   endtask : wreg
   task automatic rreg(logic [6:0] a);
      @(posedge i_clk);
      addr <= a;
      rd <= 1;
      cyc(1);
      rd <= 0;
      r = rdat;
      chk("rvalid", {15'h0, rv}, 16'h0001);
   endtask : rreg
   task automatic snd(logic [15:0] d, logic b);
      @(posedge i_clk);
      go <= 1;
      word <= d;
      bad <= b;
      @(posedge i_clk);
      go <= 0;
   endtask : snd
   task automatic clr;
      @(posedge i_clk);
      aclr <= 1;
      @(posedge i_clk);
      aclr <= 0;
      cyc(1);
      chk("alarms_clear", {apat, apar}, 16'h0000);
   endtask : clr
   task automatic t_reg;
      chk("aen_reset", {15'h0, aen}, 16'h0000);
      chk("low_reset", {9'h0, low}, 16'h000e);
      rreg(7'h01);
      chk("cfg_reset", r, 16'h050e);
      wreg(7'h01, 16'hffff);
      wreg(7'h02, 16'h0000);
      rreg(7'h01);
      chk("cfg_rsvd", r, 16'h9fff);
      rreg(7'h02);
      chk("unmapped", r, 16'h0000);
      pat <= 16'h1234;
      snd(16'h1234, 0);
      cyc(1);
      chk("test_dv_aen", {dv, aen, iot}, 16'h0001);
      clr;
      snd(16'h1235, 0);
      cyc(2);
      chk("pattern_alarm", {15'h0, apat}, 16'h0001);
      $display("test reg done");
   endtask : t_reg
   task automatic t_par;
      for (int m = 0; m < 4; m++) begin
         odd <= m[0];
         // The unused parity source carries the wrong bit, so a swapped source shows
         wflip <= m[1];
         wreg(7'h01, {4'h0, m[0], !m[1], m[1], 9'h100});
         clr;
         snd(16'h00a7 << m, 0);
         cyc(2);
         chk("par_good", {15'h0, apar}, 16'h0000);
         snd(16'h0f31, 1);
         cyc(2);
         chk("par_bad", {15'h0, apar}, 16'h0001);
      end
      wflip <= 0;
      $display("test parity done");
   endtask : t_par
   task automatic t_inv;
      odd <= 0;
      wreg(7'h01, 16'h0580);
      snd(16'h3c5a, 0);
      cyc(1);
      chk("inv_a", cha, 16'hc3a5);
      chk("aen_normal", {15'h0, aen}, 16'h0001);
      wreg(7'h01, 16'h0500);
      snd(16'h3c5a, 0);
      cyc(1);
      chk("plain_a", cha, 16'h3c5a);
      $display("test invert done");
   endtask : t_inv
   task automatic t_chan;
      @(posedge i_clk);
      code <= 2'h3;
      wreg(7'h01, 16'h0400);
      cyc(2);
      chk("dual", {12'h0, act}, 16'h0006);
      wreg(7'h01, 16'h0500);
      cyc(2);
      chk("quad", {12'h0, act}, 16'h000f);
      $display("test channels done");
   endtask : t_chan
   task automatic t_auto;
      wreg(7'h01, 16'h1500);
      clr;
      snd(16'h0001, 1);
      repeat (3) snd(16'h0003, 0);
      cyc(3);
      chk("auto_early", {15'h0, apar}, 16'h0001);
      snd(16'h0003, 0);
      cyc(3);
      chk("auto_clear", {15'h0, apar}, 16'h0000);
      cyc(2);
      $display("test autoclear done");
   endtask : t_auto
   task automatic summarize;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : summarize
   initial begin
      repeat (8) @(posedge i_clk);
      i_rst_n <= 1;
      t_reg;
      t_par;
      t_inv;
      t_chan;
      t_auto;
      summarize;
   end
   initial begin
      #200000;
      failures++;
      summarize;
   end
endmodule : input_check_channel_config_tb
